// File: logic/opps_pkg.sv
// package: register map, field layout and reset values for the optical port
package opps_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFF_MAX_WIDTH = 16'h210a;
  localparam logic [15:0] OFF_INTERVAL = 16'h210b;
  localparam logic [15:0] OFF_POLARITY = 16'h210c;
  localparam logic [15:0] OFF_TX_CFG = 16'h2456;
  localparam logic [15:0] OFF_RX_CFG = 16'h2457;
  // field positions
  localparam int TX_INV_BIT = 0;
  localparam int TX_MOD_BIT = 1;
  localparam int TX_SRC_LSB = 2;
  localparam int RX_BB_BIT = 0;
  localparam int RX_INV_BIT = 1;
  localparam int RX_DIS_BIT = 2;
  localparam int RX_DUTY_LSB = 4;
  localparam int POL_INV_BIT = 0;
  // reset values
  localparam logic [7:0] RST_MAX_WIDTH = 8'hff;
  localparam logic [7:0] RST_INTERVAL = 8'h00;
  localparam logic [7:0] RST_TX_CFG = 8'h00;
  localparam logic [7:0] RST_RX_CFG = 8'h00;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  // timing: interval unit in filter clocks, limit disable value
  localparam int SPACING_UNIT = 4;
  localparam logic [7:0] WIDTH_NO_LIMIT = 8'hff;
  localparam int PULSE_CNT_W = 18;
  localparam int CARRIER_W = 4;

  typedef enum logic [1:0] {
    OPPS_SRC_GPIO = 2'h0,
    OPPS_SRC_UART = 2'h1,
    OPPS_SRC_REAL = 2'h2,
    OPPS_SRC_REACT = 2'h3
  } opps_src_e;

  typedef enum logic [2:0] {
    OPPS_P_IDLE = 3'b001,
    OPPS_P_HIGH = 3'b010,
    OPPS_P_LOW = 3'b100
  } opps_pst_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } opps_bus_s;

  typedef struct packed {
    logic out;
    logic oe;
  } opps_pin_s;
endpackage : opps_pkg

// File: logic/opps_top.sv
// optical port routing, carrier modulation and energy pulse shaping
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module opps_top #(
  parameter int QUEUE_DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input opps_pkg::opps_bus_s bus_in,
  output logic [7:0] rd_data_out,
  input wire logic filter_clock_en_in,
  input wire logic carrier_en_in,
  input wire logic real_energy_req_in,
  input wire logic reactive_energy_req_in,
  input wire logic aux_pulse_x_in,
  input wire logic aux_pulse_y_in,
  input wire logic [63:0] segment_map_in,
  input wire logic ir_receive_pin_in,
  output logic uart_rx_out,
  output logic gpio_fifty_five_out,
  output logic gpio_five_out,
  output logic segment_fifty_five_sel_out,
  input wire logic uart_tx_in,
  input wire logic gpio_fifty_one_in,
  input wire logic segment_fifty_one_in,
  output opps_pkg::opps_pin_s ir_transmit_pin_out,
  output logic real_energy_pulse_out,
  output logic reactive_energy_pulse_out,
  output logic aux_pulse_x_out,
  output logic aux_pulse_y_out
);
  import opps_pkg::*;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] max_width_q, interval_q, tx_cfg_q, rx_cfg_q, pol_q;
  logic ir_tx_invert, ir_tx_modulate_enable, ir_rx_bitbang_select;
  logic ir_rx_invert, ir_rx_disable, pulse_polarity_invert;
  logic [1:0] ir_tx_source_select, ir_carrier_duty;
  logic [1:0] live_q;

  assign ir_tx_invert = tx_cfg_q[TX_INV_BIT];
  assign ir_tx_modulate_enable = tx_cfg_q[TX_MOD_BIT];
  assign ir_tx_source_select = tx_cfg_q[TX_SRC_LSB +: 2];
  assign ir_rx_bitbang_select = rx_cfg_q[RX_BB_BIT];
  assign ir_rx_invert = rx_cfg_q[RX_INV_BIT];
  assign ir_rx_disable = rx_cfg_q[RX_DIS_BIT];
  assign ir_carrier_duty = rx_cfg_q[RX_DUTY_LSB +: 2];
  assign pulse_polarity_invert = pol_q[POL_INV_BIT];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      max_width_q <= RST_MAX_WIDTH;
      interval_q <= RST_INTERVAL;
      tx_cfg_q <= RST_TX_CFG;
      rx_cfg_q <= RST_RX_CFG;
      pol_q <= RST_POLARITY;
    end else if (bus_in.wr) begin
      if (bus_in.addr == OFF_MAX_WIDTH) begin
        max_width_q <= bus_in.wdata;
      end else if (bus_in.addr == OFF_INTERVAL) begin
        interval_q <= bus_in.wdata;
      end else if (bus_in.addr == OFF_POLARITY) begin
        pol_q <= {7'h00, bus_in.wdata[POL_INV_BIT]};
      end else if (bus_in.addr == OFF_TX_CFG) begin
        tx_cfg_q <= {4'h0, bus_in.wdata[3:0]};
      end else if (bus_in.addr == OFF_RX_CFG) begin
        rx_cfg_q <= {2'h0, bus_in.wdata[5:4], 1'b0, bus_in.wdata[2:0]};
      end
    end
  end

  // read data stands only in the cycle after the strobe; unmapped read 0
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (bus_in.rd) begin
      if (bus_in.addr == OFF_MAX_WIDTH) begin
        rd_data_out <= max_width_q;
      end else if (bus_in.addr == OFF_INTERVAL) begin
        rd_data_out <= interval_q;
      end else if (bus_in.addr == OFF_POLARITY) begin
        rd_data_out <= {5'h00, live_q, pol_q[0]};
      end else if (bus_in.addr == OFF_TX_CFG) begin
        rd_data_out <= tx_cfg_q;
      end else if (bus_in.addr == OFF_RX_CFG) begin
        rd_data_out <= rx_cfg_q;
      end else begin
        rd_data_out <= 8'h00;
      end
    end else begin
      rd_data_out <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------------
  // pin is asynchronous: three stages, change accepted when 2nd and 3rd agree
  logic rx_s1_q, rx_s2_q, rx_s3_q, rx_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
      rx_q <= 1'b1;
    end else begin
      rx_s1_q <= ir_receive_pin_in;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) begin
        rx_q <= rx_s3_q;
      end
    end
  end

  logic rx_seg, rx_is_uart;
  assign rx_seg = segment_map_in[55];
  assign rx_is_uart = !rx_seg && !ir_rx_disable && !ir_rx_bitbang_select;
  assign segment_fifty_five_sel_out = rx_seg;
  // idle high when not routed so the uart sees no false start bit
  assign uart_rx_out = rx_is_uart ? (rx_q ^ ir_rx_invert) : 1'b1;
  assign gpio_fifty_five_out = (!rx_seg && ir_rx_disable) ? rx_q
                               : 1'b0;
  assign gpio_five_out = (!rx_seg && ir_rx_bitbang_select) ? rx_q
                         : 1'b0;

  // ----------------------------------------------------------------------
  // carrier: 16 steps, low portion set by the duty field
  // ----------------------------------------------------------------------
  logic [CARRIER_W-1:0] car_q;
  logic [CARRIER_W-1:0] low_len;
  logic carrier;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      car_q <= '0;
    end else if (carrier_en_in) begin
      car_q <= car_q + 1'b1;
    end
  end
  always_comb begin
    case (ir_carrier_duty)
      2'h0: low_len = 4'h8;
      2'h1: low_len = 4'h4;
      2'h2: low_len = 4'h2;
      default: low_len = 4'h1;
    endcase
  end
  assign carrier = car_q >= low_len;

  // ----------------------------------------------------------------------
  // energy pulse shaping, one generate slice per channel
  // ----------------------------------------------------------------------
  logic [1:0] req_in, act;
  assign req_in = {reactive_energy_req_in, real_energy_req_in};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic [$clog2(QUEUE_DEPTH+1)-1:0] pend_q;
      logic [PULSE_CNT_W-1:0] gap_q, wid_q, half_q;
      logic [PULSE_CNT_W-1:0] limit, spacing;
      opps_pst_e st_q;
      logic no_limit, start, gap_done;
      assign no_limit = (interval_q == 8'h00)
                        || (max_width_q == WIDTH_NO_LIMIT);
      assign limit = PULSE_CNT_W'(({1'b0, max_width_q, 1'b0} + 10'h001)
                     * interval_q);
      assign spacing = PULSE_CNT_W'(interval_q * SPACING_UNIT);
      // bypass when interval is zero: start straight from the request
      // next start may share the edge of the last spacing tick
      assign gap_done = (gap_q == '0)
                        || (gap_q == 1 && filter_clock_en_in);
      assign start = (interval_q == 8'h00) ? req_in[g]
                     : (pend_q != '0 && gap_done && st_q == OPPS_P_IDLE);
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          pend_q <= '0;
        end else if (interval_q == 8'h00) begin
          pend_q <= '0;
        end else if (req_in[g] && !start && pend_q != QUEUE_DEPTH) begin
          pend_q <= pend_q + 1'b1;
        end else if (start && !req_in[g]) begin
          pend_q <= pend_q - 1'b1;
        end
      end
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          gap_q <= '0;
        end else if (start) begin
          gap_q <= spacing;
        end else if (filter_clock_en_in && gap_q != '0) begin
          gap_q <= gap_q - 1'b1;
        end
      end
      // unlimited: active for half the spacing, or one filter clock when interval is zero, else until width limit
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          st_q <= OPPS_P_IDLE;
          wid_q <= '0;
          half_q <= '0;
        end else begin
          case (st_q)
            OPPS_P_IDLE: begin
              if (start) begin
                st_q <= OPPS_P_HIGH;
                wid_q <= limit;
                half_q <= (interval_q == 8'h00) ? PULSE_CNT_W'(1)
                          : PULSE_CNT_W'(spacing >> 1);
              end
            end
            OPPS_P_HIGH: begin
              if (filter_clock_en_in) begin
                wid_q <= wid_q - 1'b1;
                half_q <= half_q - 1'b1;
                if (no_limit ? half_q <= 1 : wid_q <= 1) begin
                  st_q <= OPPS_P_LOW;
                end
              end
            end
            OPPS_P_LOW: st_q <= OPPS_P_IDLE;
            default: st_q <= OPPS_P_IDLE;
          endcase
        end
      end
      assign act[g] = (st_q == OPPS_P_HIGH);
    end
  endgenerate

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      live_q <= 2'h0;
    end else begin
      live_q <= act;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      real_energy_pulse_out <= 1'b1;
      reactive_energy_pulse_out <= 1'b1;
      aux_pulse_x_out <= 1'b0;
      aux_pulse_y_out <= 1'b0;
    end else begin
      real_energy_pulse_out <= act[0] ^ !pulse_polarity_invert;
      reactive_energy_pulse_out <= act[1] ^ !pulse_polarity_invert;
      aux_pulse_x_out <= aux_pulse_x_in;
      aux_pulse_y_out <= aux_pulse_y_in;
    end
  end

  // ----------------------------------------------------------------------
  // transmit pin
  // ----------------------------------------------------------------------
  logic tx_src, tx_inv, tx_mod;
  always_comb begin
    case (opps_src_e'(ir_tx_source_select))
      OPPS_SRC_GPIO: tx_src = gpio_fifty_one_in;
      OPPS_SRC_UART: tx_src = uart_tx_in;
      OPPS_SRC_REAL: tx_src = real_energy_pulse_out;
      default: tx_src = reactive_energy_pulse_out;
    endcase
  end
  assign tx_inv = tx_src ^ ir_tx_invert;
  assign tx_mod = (ir_tx_modulate_enable && !tx_inv) ? carrier
                  : tx_inv;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ir_transmit_pin_out <= '0;
    end else begin
      ir_transmit_pin_out.oe <= 1'b1;
      ir_transmit_pin_out.out <= segment_map_in[51] ? segment_fifty_one_in
                                 : tx_mod;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_wr_rx;
    bus_in.wr && bus_in.addr == OFF_RX_CFG;
  endsequence
  property p_segment_fifty_five;
    @(posedge clk_in) disable iff (rst_in)
    segment_map_in[55] |-> uart_rx_out && !gpio_fifty_five_out;
  endproperty
  a_segment_fifty_five: assert property (p_segment_fifty_five) else $error("rx not segment");
  property p_rxinv;
    @(posedge clk_in) disable iff (rst_in)
    rx_is_uart |-> uart_rx_out == (rx_q ^ ir_rx_invert);
  endproperty
  a_rxinv: assert property (p_rxinv) else $error("rx invert wrong");
  property p_bb;
    @(posedge clk_in) disable iff (rst_in)
    (ir_rx_bitbang_select && !rx_seg) |-> gpio_five_out == rx_q;
  endproperty
  a_bb: assert property (p_bb) else $error("bitbang route");
  property p_duty;
    @(posedge clk_in) disable iff (rst_in)
    (ir_carrier_duty == 2'h3) |-> carrier == (car_q != 4'h0);
  endproperty
  a_duty: assert property (p_duty) else $error("duty wrong");
  property p_rxcfg;
    @(posedge clk_in) disable iff (rst_in)
    s_wr_rx |=> rx_cfg_q[2:0] == $past(bus_in.wdata[2:0]);
  endproperty
  a_rxcfg: assert property (p_rxcfg) else $error("rx cfg lost");
  property p_tx;
    @(posedge clk_in) disable iff (rst_in)
    !segment_map_in[51] |=> ir_transmit_pin_out.out == $past(tx_mod);
  endproperty
  a_tx: assert property (p_tx) else $error("tx source");
  property p_mod;
    @(posedge clk_in) disable iff (rst_in)
    (ir_tx_modulate_enable && tx_inv) |-> tx_mod;
  endproperty
  a_mod: assert property (p_mod) else $error("mod on one");
  property p_pol;
    @(posedge clk_in) disable iff (rst_in)
    (!pulse_polarity_invert && !act[0]) |=> real_energy_pulse_out;
  endproperty
  a_pol: assert property (p_pol) else $error("idle polarity");
  property p_bypass;
    @(posedge clk_in) disable iff (rst_in)
    (interval_q == 8'h00 && real_energy_req_in && !act[0]
     && g_ch[0].st_q == OPPS_P_IDLE) |=> act[0];
  endproperty
  a_bypass: assert property (p_bypass) else $error("no bypass");
  property p_aux;
    @(posedge clk_in) disable iff (rst_in)
    aux_pulse_y_in |=> aux_pulse_y_out;
  endproperty
  a_aux: assert property (p_aux) else $error("aux y lost");
endmodule : opps_top

// File: sim/opps_ir_partner.sv
// far side model: ir transceiver with photodiode and led dark counter
`timescale 1ns/1ps
module opps_ir_partner (
  input wire logic clk_in,
  input opps_pkg::opps_pin_s tx_pin_in,
  input wire logic light_in,
  input wire logic clr_in,
  output logic rx_pin_out,
  output logic [7:0] dark_cnt_out
);
  import opps_pkg::*;
  // ----------------------------------------
  // receive side and led observation
  // ----------------------------------------
  // photodiode answers one clock late, like a slow front end
  always_ff @(posedge clk_in) begin
    rx_pin_out <= light_in;
  end
  // counts cycles with the led dark while the pin is driven
  always_ff @(posedge clk_in) begin
    if (clr_in) begin
      dark_cnt_out <= 8'h00;
    end else if (tx_pin_in.oe && !tx_pin_in.out) begin
      dark_cnt_out <= dark_cnt_out + 8'h01;
    end
  end
endmodule : opps_ir_partner

// File: sim/tb.sv
// testbench for the optical port and pulse shaper
`timescale 1ns/1ps
module tb;
  import opps_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  opps_bus_s bus = '0;
  logic [63:0] map = '0;
  logic fen = 1'b1, cen = 1'b1, real_req = 1'b0, react_req = 1'b0;
  logic ax = 1'b0, ay = 1'b0, light = 1'b0, clr = 1'b0, pol = 1'b0;
  logic utx = 1'b0, g51 = 1'b0, s51 = 1'b0;
  logic rx_pin, u_rx, g55, g5, segment_fifty_five, real_o, react_o, ax_o, ay_o;
  logic [7:0] rd_data, dark, d;
  opps_pin_s txp;
  int num_errors = 0, compares = 0, lat, wid, gap;
  // rows: rx cfg, map55, pin, expected {seg, uart, gpio55, gpio5}
  logic [13:0] rx_tab [6] = '{14'h0000, 14'h0084, 14'h0090,
                              14'h0196, 14'h0055, 14'h017c};
  // rows: tx cfg, map51, gpio51, uart tx, segment_fifty_one, expected pin
  logic [12:0] tx_tab [6] = '{13'h0009, 13'h0004, 13'h0085,
                              13'h00a4, 13'h0093, 13'h0021};
  logic [7:0] mw_tab [3] = '{8'h00, 8'h01, 8'hff};
  int wid_tab [3] = '{2, 6, 4};

  always #2.5 clk_in = ~clk_in;

  opps_top i_dut (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .bus_in(bus),
    .rd_data_out(rd_data),
    .filter_clock_en_in(fen),
    .carrier_en_in(cen),
    .real_energy_req_in(real_req),
    .reactive_energy_req_in(react_req),
    .aux_pulse_x_in(ax),
    .aux_pulse_y_in(ay),
    .segment_map_in(map),
    .ir_receive_pin_in(rx_pin),
    .uart_rx_out(u_rx),
    .gpio_fifty_five_out(g55),
    .gpio_five_out(g5),
    .segment_fifty_five_sel_out(segment_fifty_five),
    .uart_tx_in(utx),
    .gpio_fifty_one_in(g51),
    .segment_fifty_one_in(s51),
    .ir_transmit_pin_out(txp),
    .real_energy_pulse_out(real_o),
    .reactive_energy_pulse_out(react_o),
    .aux_pulse_x_out(ax_o),
    .aux_pulse_y_out(ay_o)
  );

  opps_ir_partner i_partner (
    .clk_in(clk_in),
    .tx_pin_in(txp),
    .light_in(light),
    .clr_in(clr),
    .rx_pin_out(rx_pin),
    .dark_cnt_out(dark)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic complete_run();
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_in);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= v;
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask : reg_wr

  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 d = rd_data;
    chk({8'h00, d}, {8'h00, exp});
  endtask : rdchk

  // settle the pin, then zero the dark counter
  task automatic dark_clr();
    cyc(3);
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
  endtask : dark_clr

  // dark cycles over one 16-step carrier period
  task automatic duty(input logic [7:0] exp);
    dark_clr();
    cyc(16);
    chk({8'h00, dark}, {8'h00, exp});
  endtask : duty

  task automatic meas(input logic r, output int l, output int w);
    l = 0;
    w = 0;
    // bounded: a stuck pulse output must not hang the run
    while ((r ? react_o : real_o) !== pol && l < 300) begin
      cyc(1);
      l++;
    end
    while ((r ? react_o : real_o) === pol && w < 300) begin
      cyc(1);
      w++;
    end
    if (l >= 300 || w >= 300) begin
      num_errors++;
      complete_run();
    end
  endtask : meas

  task automatic fire(input logic r, input int n);
    @(posedge clk_in);
    if (r) react_req <= 1'b1;
    else real_req <= 1'b1;
    repeat (n) @(posedge clk_in);
    react_req <= 1'b0;
    real_req <= 1'b0;
    #1 meas(r, lat, wid);
  endtask : fire

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rdchk(OFF_MAX_WIDTH, 8'hff);
    rdchk(OFF_INTERVAL, 8'h00);
    rdchk(OFF_TX_CFG, 8'h00);
    rdchk(OFF_RX_CFG, 8'h00);
    rdchk(OFF_POLARITY, 8'h00);
    reg_wr(16'h2458, 8'hff);
    rdchk(16'h2458, 8'h00);
    reg_wr(OFF_TX_CFG, 8'hff);
    rdchk(OFF_TX_CFG, 8'h0f);
    reg_wr(OFF_RX_CFG, 8'hff);
    rdchk(OFF_RX_CFG, 8'h37);
    reg_wr(OFF_MAX_WIDTH, 8'h5a);
    rdchk(OFF_MAX_WIDTH, 8'h5a);
    for (int i = 0; i < 6; i++) begin
      reg_wr(OFF_RX_CFG, rx_tab[i][13:6]);
      map[55] <= rx_tab[i][5];
      light <= rx_tab[i][4];
      cyc(8);
      chk(16'({segment_fifty_five, u_rx, g55, g5}), 16'(rx_tab[i][3:0]));
    end
    for (int i = 0; i < 6; i++) begin
      reg_wr(OFF_TX_CFG, tx_tab[i][12:5]);
      {map[51], g51, utx, s51} <= tx_tab[i][4:1];
      cyc(3);
      chk({14'h0000, txp.oe, txp.out}, {14'h0001, tx_tab[i][0]});
    end
    // inverted high level becomes zero, so the carrier must appear
    g51 <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      reg_wr(OFF_RX_CFG, {2'h0, k[1:0], 4'h0});
      reg_wr(OFF_TX_CFG, 8'h03);
      duty(8'h08 >> k);
    end
    reg_wr(OFF_TX_CFG, 8'h02);
    duty(8'h00);
    reg_wr(OFF_MAX_WIDTH, 8'h01);
    chk({14'h0000, real_o, react_o}, 16'h0003);
    // pin follows the real pulse: low for its one active cycle
    reg_wr(OFF_TX_CFG, 8'h08);
    dark_clr();
    fire(1'b0, 1);
    chk(16'(lat <= 3), 16'h0001);
    chk(16'(wid), 16'h0001);
    cyc(3);
    chk({8'h00, dark}, 16'h0001);
    reg_wr(OFF_POLARITY, 8'h01);
    pol = 1'b1;
    ax <= 1'b1;
    ay <= 1'b1;
    cyc(3);
    chk({12'h000, real_o, react_o, ax_o, ay_o}, 16'h0003);
    // inverted reactive pulse: pin drops only while it is active
    reg_wr(OFF_TX_CFG, 8'h0d);
    dark_clr();
    fire(1'b1, 1);
    chk(16'(lat <= 3), 16'h0001);
    cyc(3);
    chk({8'h00, dark}, 16'h0001);
    // spacing of two interval units, eight filter clocks, per pulse
    reg_wr(OFF_INTERVAL, 8'h02);
    for (int i = 0; i < 3; i++) begin
      reg_wr(OFF_MAX_WIDTH, mw_tab[i]);
      cyc(20);
      fire(1'b0, 2);
      chk(16'(wid), 16'(wid_tab[i]));
      meas(1'b0, gap, lat);
      chk(16'(wid + gap), 16'(2 * SPACING_UNIT));
      chk(16'(lat), 16'(wid_tab[i]));
    end
    complete_run();
  end
endmodule : tb
